// [rtl/ptt_timer.sv]
// Top of the periodic tick timer: AXI4-Lite registers, request level and acknowledge vectoring.
// Assumes one clock aclk, synchronous inputs and a single master issuing one access at a time.
//
// Added by the designer: the address map and the AXI4-Lite register port.
`timescale 1ns/1ps
`include "ptt_defines.svh"
module ptt_timer (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic clk_en,
    input wire logic crystal_reference_input,
    input wire logic clock_mode_input,
    input wire ptt_pkg::ptt_level_t ext_irq_level,
    input wire logic iack_strobe,
    input wire ptt_pkg::ptt_level_t iack_level,
    output ptt_pkg::ptt_level_t irq_level_q,
    output logic iack_done_q,
    output logic iack_own_q,
    output ptt_pkg::ptt_vector_t iack_vector_q,
    output logic irq_q,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready
);
    import ptt_pkg::*;

    // Maps a byte address onto a register selector.
    function automatic ptt_sel_t decode(input logic [7:0] addr);
        case (addr)
            `PTT_OFS_CONTROL: decode = PTT_SEL_CONTROL;
            `PTT_OFS_TIMER: decode = PTT_SEL_TIMER;
            `PTT_OFS_STATUS: decode = PTT_SEL_STATUS;
            `PTT_OFS_MASK: decode = PTT_SEL_MASK;
            `PTT_OFS_COUNT: decode = PTT_SEL_COUNT;
            default: decode = PTT_SEL_NONE;
        endcase
    endfunction

    // Register state.
    ptt_level_t request_level_select_q;
    ptt_vector_t periodic_vector_field_q;
    logic prescale_select_q;
    ptt_modulus_t timing_modulus_q;
    logic [`PTT_NUM_EVENTS-1:0] status_q;
    logic [`PTT_NUM_EVENTS-1:0] mask_q;
    logic pending_q;
    ptt_level_t pending_level_q;

    // Bus state.
    logic aw_have_q;
    logic w_have_q;
    logic [7:0] awaddr_q;
    logic [31:0] wdata_q;
    logic [3:0] wstrb_q;

    // Counter outputs.
    logic expire;
    ptt_modulus_t count_now;

    ptt_counter u_counter (
        .aclk(aclk),
        .aresetn(aresetn),
        .clk_en(clk_en),
        .crystal_reference_input(crystal_reference_input),
        .prescale_select(prescale_select_q),
        .timing_modulus(timing_modulus_q),
        .expire_q(expire),
        .count_q(count_now)
    );

    // Write channel handshakes; address and data may arrive in either order.
    wire aw_take = s_axi_awvalid & s_axi_awready;
    wire w_take = s_axi_wvalid & s_axi_wready;
    wire aw_hold = aw_have_q | aw_take;
    wire w_hold = w_have_q | w_take;
    wire do_wr = aw_hold & w_hold & ~s_axi_bvalid;
    wire [7:0] wr_addr = aw_take ? s_axi_awaddr : awaddr_q;
    wire [31:0] wr_data = w_take ? s_axi_wdata : wdata_q;
    wire [3:0] wr_strb = w_take ? s_axi_wstrb : wstrb_q;
    wire ptt_sel_t wr_sel = decode(wr_addr);
    wire wr_lo = do_wr & wr_strb[0];
    wire wr_hi = do_wr & wr_strb[1];
    wire wr_ctl = (wr_sel == PTT_SEL_CONTROL);
    wire wr_tmr = (wr_sel == PTT_SEL_TIMER);
    wire wr_msk = (wr_sel == PTT_SEL_MASK);
    wire aw_have_d = aw_hold & ~do_wr;
    wire w_have_d = w_hold & ~do_wr;
    wire bvalid_d = do_wr | (s_axi_bvalid & ~s_axi_bready);
    wire [1:0] bresp_d = (wr_sel == PTT_SEL_NONE) ? `PTT_RESP_SLVERR : `PTT_RESP_OKAY;

    // Read channel; data are captured when the address is taken.
    wire ar_take = s_axi_arvalid & s_axi_arready;
    wire ptt_sel_t rd_sel = decode(s_axi_araddr);
    wire rvalid_d = ar_take | (s_axi_rvalid & ~s_axi_rready);
    wire rd_status = ar_take && (rd_sel == PTT_SEL_STATUS);
    wire [31:0] ctl_word = {21'h0, request_level_select_q, periodic_vector_field_q};
    wire [31:0] tmr_word = {23'h0, prescale_select_q, timing_modulus_q};
    wire [31:0] sts_word = {{(32-`PTT_NUM_EVENTS){1'b0}}, status_q};
    wire [31:0] msk_word = {{(32-`PTT_NUM_EVENTS){1'b0}}, mask_q};
    wire [31:0] cnt_word = {24'h000000, count_now};
    wire [31:0] rd_word =
        (rd_sel == PTT_SEL_CONTROL) ? ctl_word :
        (rd_sel == PTT_SEL_TIMER) ? tmr_word :
        (rd_sel == PTT_SEL_STATUS) ? sts_word :
        (rd_sel == PTT_SEL_MASK) ? msk_word :
        (rd_sel == PTT_SEL_COUNT) ? cnt_word : 32'h00000000;
    wire [1:0] rresp_d = (rd_sel == PTT_SEL_NONE) ? `PTT_RESP_SLVERR : `PTT_RESP_OKAY;

    // Periodic request: expiry arms it only while a level is selected, acknowledge clears it.
    wire level_enabled = (request_level_select_q != 3'h0);
    wire arm = expire & level_enabled;
    wire ack_match = iack_strobe && pending_q && (iack_level == pending_level_q);
    wire pending_d = arm | (pending_q & ~ack_match);
    wire ptt_level_t pending_level_d = arm ? request_level_select_q : pending_level_q;
    wire ptt_level_t own_level = pending_d ? pending_level_d : 3'h0;
    wire ptt_level_t level_d = (own_level >= ext_irq_level) ? own_level : ext_irq_level;

    // Sticky event bits; a new event wins over the read that clears it.
    wire [`PTT_NUM_EVENTS-1:0] event_set = {ack_match, expire};
    logic [`PTT_NUM_EVENTS-1:0] status_d;
    genvar gi;
    generate
        for (gi = 0; gi < `PTT_NUM_EVENTS; gi++) begin : g_status
            assign status_d[gi] = event_set[gi] | (status_q[gi] & ~rd_status);
        end
    endgenerate
    wire irq_d = |(status_d & mask_q);

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_have_q <= 1'b0;
            w_have_q <= 1'b0;
            awaddr_q <= 8'h00;
            wdata_q <= 32'h00000000;
            wstrb_q <= 4'h0;
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `PTT_RESP_OKAY;
        end else if (clk_en) begin
            aw_have_q <= aw_have_d;
            w_have_q <= w_have_d;
            if (aw_take) begin
                awaddr_q <= s_axi_awaddr;
            end
            if (w_take) begin
                wdata_q <= s_axi_wdata;
                wstrb_q <= s_axi_wstrb;
            end
            s_axi_awready <= ~aw_have_d & ~bvalid_d;
            s_axi_wready <= ~w_have_d & ~bvalid_d;
            s_axi_bvalid <= bvalid_d;
            if (do_wr) begin
                s_axi_bresp <= bresp_d;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h00000000;
            s_axi_rresp <= `PTT_RESP_OKAY;
        end else if (clk_en) begin
            s_axi_arready <= ~rvalid_d;
            s_axi_rvalid <= rvalid_d;
            if (ar_take) begin
                s_axi_rdata <= rd_word;
                s_axi_rresp <= rresp_d;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            request_level_select_q <= `PTT_RST_LEVEL;
            periodic_vector_field_q <= `PTT_RST_VECTOR;
        end else if (clk_en && wr_ctl) begin
            if (wr_hi) begin
                request_level_select_q <= wr_data[`PTT_CTL_LEVEL_HI:`PTT_CTL_LEVEL_LO];
            end
            if (wr_lo) begin
                periodic_vector_field_q <= wr_data[`PTT_CTL_VEC_HI:`PTT_CTL_VEC_LO];
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            prescale_select_q <= ~clock_mode_input;
            timing_modulus_q <= `PTT_RST_MODULUS;
        end else if (clk_en && wr_tmr) begin
            if (wr_hi) begin
                prescale_select_q <= wr_data[`PTT_TMR_PRESCALE];
            end
            if (wr_lo) begin
                timing_modulus_q <= wr_data[`PTT_TMR_MOD_HI:`PTT_TMR_MOD_LO];
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            mask_q <= '0;
            status_q <= '0;
            irq_q <= 1'b0;
        end else if (clk_en) begin
            if (wr_msk && wr_lo) begin
                mask_q <= wr_data[`PTT_NUM_EVENTS-1:0];
            end
            status_q <= status_d;
            irq_q <= irq_d;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pending_q <= 1'b0;
            pending_level_q <= 3'h0;
            irq_level_q <= 3'h0;
            iack_done_q <= 1'b0;
            iack_own_q <= 1'b0;
            iack_vector_q <= 8'h00;
        end else if (clk_en) begin
            pending_q <= pending_d;
            pending_level_q <= pending_level_d;
            irq_level_q <= level_d;
            iack_done_q <= iack_strobe;
            iack_own_q <= ack_match;
            iack_vector_q <= ack_match ? periodic_vector_field_q : 8'h00;
        end
    end
endmodule // ptt_timer

// [rtl/ptt_defines.svh]
// Constants for the periodic tick timer: register offsets, field positions, reset values, counts.
// Assumes it is included by bare name from the design modules, the checker and the bench.
//
// Summary of operation
// - Level field picks request level, zero disables.
// - Timer wins over external request at equal level.
// - Counter keeps running while level field zero.
// - Acknowledge returns programmed eight-bit vector.
// - Zero modulus stops the timer completely; the reference divider and, when selected, the prescaler keep counting.
// - Timer register always accessible, bits 15:9 zero.
// - Prescale select divides input clock by 512.
// - Reset loads prescale select from inverted mode.
// - Period equals modulus times prescale times four.
// - Low byte holds eight-bit count modulus.
// - Control bits 10:0 accessible, 15:11 read zero.
`ifndef PTT_DEFINES_SVH
`define PTT_DEFINES_SVH

`define PTT_OFS_CONTROL 8'h00
`define PTT_OFS_TIMER 8'h04
`define PTT_OFS_STATUS 8'h08
`define PTT_OFS_MASK 8'h0C
`define PTT_OFS_COUNT 8'h10

`define PTT_CTL_LEVEL_HI 10
`define PTT_CTL_LEVEL_LO 8
`define PTT_CTL_VEC_HI 7
`define PTT_CTL_VEC_LO 0
`define PTT_TMR_PRESCALE 8
`define PTT_TMR_MOD_HI 7
`define PTT_TMR_MOD_LO 0

`define PTT_RST_LEVEL 3'h0
`define PTT_RST_VECTOR 8'h0F
`define PTT_RST_MODULUS 8'h00

`define PTT_ST_EXPIRE 0
`define PTT_ST_ACK 1
`define PTT_NUM_EVENTS 2

`define PTT_REF_DIV 4
`define PTT_PRESCALE 512

`define PTT_RESP_OKAY 2'h0
`define PTT_RESP_SLVERR 2'h2

`endif

// [rtl/ptt_pkg.sv]
// Types shared by the periodic tick timer modules.
// Assumes ptt_defines.svh is on the include path.
package ptt_pkg;
    typedef logic [2:0] ptt_level_t;
    typedef logic [7:0] ptt_vector_t;
    typedef logic [7:0] ptt_modulus_t;
    typedef enum logic [2:0] {
        PTT_SEL_NONE,
        PTT_SEL_CONTROL,
        PTT_SEL_TIMER,
        PTT_SEL_STATUS,
        PTT_SEL_MASK,
        PTT_SEL_COUNT
    } ptt_sel_t;
endpackage

// [rtl/ptt_counter.sv]
// Reference divider, optional prescaler and modulus down counter of the periodic tick timer.
// Assumes crystal_reference_input is synchronous to aclk and no faster than aclk / 2.
`timescale 1ns/1ps
`include "ptt_defines.svh"
module ptt_counter (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic clk_en,
    input wire logic crystal_reference_input,
    input wire logic prescale_select,
    input wire ptt_pkg::ptt_modulus_t timing_modulus,
    output logic expire_q,
    output ptt_pkg::ptt_modulus_t count_q
);
    import ptt_pkg::*;

    localparam int REF_W = $clog2(`PTT_REF_DIV);
    localparam int PRE_W = $clog2(`PTT_PRESCALE);
    localparam logic [REF_W-1:0] REF_LAST = REF_W'(`PTT_REF_DIV - 1);
    localparam logic [PRE_W-1:0] PRE_LAST = PRE_W'(`PTT_PRESCALE - 1);

    logic ref_q;
    logic [REF_W-1:0] ref_cnt_q;
    logic [PRE_W-1:0] pre_cnt_q;
    ptt_modulus_t count_d;
    logic expire_d;

    wire ref_rise = crystal_reference_input & ~ref_q;
    wire quarter_tick = ref_rise && (ref_cnt_q == REF_LAST);
    wire pre_wrap = (pre_cnt_q == PRE_LAST);
    wire count_tick = quarter_tick && (!prescale_select || pre_wrap);
    wire stopped = (timing_modulus == 8'h00);

    always_comb begin
        count_d = count_q;
        expire_d = 1'b0;
        if (stopped) begin
            count_d = 8'h00;
        end else if (count_tick) begin
            if (count_q == 8'h00) begin
                count_d = timing_modulus;
            end else if (count_q == 8'h01) begin
                count_d = timing_modulus;
                expire_d = 1'b1;
            end else begin
                count_d = count_q - 8'h01;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ref_q <= 1'b0;
            ref_cnt_q <= '0;
            pre_cnt_q <= '0;
            count_q <= `PTT_RST_MODULUS;
            expire_q <= 1'b0;
        end else if (clk_en) begin
            ref_q <= crystal_reference_input;
            if (ref_rise) begin
                ref_cnt_q <= ref_cnt_q + REF_W'(1);
            end
            if (quarter_tick) begin
                pre_cnt_q <= prescale_select ? pre_cnt_q + PRE_W'(1) : '0;
            end
            count_q <= count_d;
            expire_q <= expire_d;
        end
    end
endmodule // ptt_counter

// [sim/ptt_timer_properties.sv]
// Port checker for the periodic tick timer, bound to its top module.
// Assumes one clock aclk and a synchronous active low reset.
`timescale 1ns/1ps
`include "ptt_defines.svh"
module ptt_timer_properties (
    input wire logic aclk,
    input wire logic aresetn,
    input wire ptt_pkg::ptt_level_t ext_irq_level,
    input wire logic iack_strobe,
    input wire ptt_pkg::ptt_level_t iack_level,
    input wire ptt_pkg::ptt_level_t irq_level_q,
    input wire logic iack_done_q,
    input wire logic iack_own_q,
    input wire ptt_pkg::ptt_vector_t iack_vector_q,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready
);
    import ptt_pkg::*;
    logic [7:0] ra_q;
    always_ff @(posedge aclk) begin
        if (!aresetn) ra_q <= 8'h00;
        else if (s_axi_arvalid && s_axi_arready) ra_q <= s_axi_araddr;
    end
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    ack_answer_a: assert property (iack_strobe |=> iack_done_q && (iack_own_q || iack_vector_q == 8'h00))
        else $error("Acknowledge answer wrong.");
    own_level_a: assert property (iack_own_q |-> $past(iack_level) != 3'h0 && $past(iack_level) <= $past(irq_level_q))
        else $error("Vector served at a wrong level.");
    lvl_floor_a: assert property ($past(aresetn) |-> irq_level_q >= $past(ext_irq_level))
        else $error("Request level below external level.");
    blat_a: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |=> s_axi_bvalid)
        else $error("Write response late.");
    bhold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("Write response dropped.");
    rhold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("Read data dropped.");
    ctl_zero_a: assert property (s_axi_rvalid && ra_q == `PTT_OFS_CONTROL |-> s_axi_rdata[31:11] == 21'h0)
        else $error("Control upper bits not zero.");
    tmr_zero_a: assert property (s_axi_rvalid && ra_q == `PTT_OFS_TIMER |-> s_axi_rdata[31:9] == 23'h0)
        else $error("Timer upper bits not zero.");
endmodule // ptt_timer_properties
bind ptt_timer ptt_timer_properties chk_u (.aclk, .aresetn, .ext_irq_level, .iack_strobe,
    .iack_level, .irq_level_q, .iack_done_q, .iack_own_q, .iack_vector_q, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rvalid, .s_axi_rready);

// [sim/ptt_iack_model.sv]
// Processor side model that acknowledges every request level it sees.
// Assumes irq_level is synchronous to aclk; slow adds a random wait.
`timescale 1ns/1ps
module ptt_iack_model (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic slow,
    input wire ptt_pkg::ptt_level_t irq_level,
    output logic iack_strobe,
    output ptt_pkg::ptt_level_t iack_level
);
    import ptt_pkg::*;
    initial begin
        iack_strobe = 1'b0;
        iack_level = 3'h0;
        forever begin
            @(posedge aclk);
            if (aresetn && irq_level != 0) begin
                repeat (slow ? $urandom_range(20, 1) : 0) @(posedge aclk);
                iack_level <= irq_level;
                iack_strobe <= 1'b1;
                @(posedge aclk);
                iack_strobe <= 1'b0;
                iack_level <= ~iack_level;
                @(posedge aclk);
            end
        end
    end
endmodule // ptt_iack_model

// [sim/ptt_timer_tb_top.sv]
// Self-checking bench of the periodic tick timer.
// Assumes the design, the checker and the acknowledge model are compiled first.
`timescale 1ns/1ps
`include "ptt_defines.svh"
module ptt_timer_tb_top;
    import ptt_pkg::*;
    logic aclk = 0, aresetn = 0, clk_en = 1, crystal_reference_input = 0, clock_mode_input = 0;
    logic iack_strobe, iack_done_q, iack_own_q, irq_q, slow = 0;
    ptt_level_t ext_irq_level = 0, iack_level, irq_level_q;
    ptt_vector_t iack_vector_q, own_vec;
    logic [7:0] s_axi_awaddr = 0, s_axi_araddr = 0;
    logic [31:0] s_axi_wdata = 0, s_axi_rdata, d, v;
    logic [3:0] s_axi_wstrb = 4'hF;
    logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0, s_axi_rready = 0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0] s_axi_bresp, s_axi_rresp, r;
    int n_fail = 0, n_checks = 0, own_cnt = 0, m;
    time own_t, t1;
    always #2.5 aclk = ~aclk;
    always @(posedge aclk) crystal_reference_input <= ~crystal_reference_input;
    always @(posedge aclk) begin
        if (iack_own_q === 1'b1) begin
            own_cnt <= own_cnt + 1;
            own_t <= $time;
            own_vec <= iack_vector_q;
        end
    end
    ptt_timer dut_u (.aclk, .aresetn, .clk_en, .crystal_reference_input, .clock_mode_input,
        .ext_irq_level, .iack_strobe, .iack_level, .irq_level_q, .iack_done_q, .iack_own_q,
        .iack_vector_q, .irq_q, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
        .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
        .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
        .s_axi_rvalid, .s_axi_rready);
    ptt_iack_model ack_u (.aclk, .aresetn, .slow, .irq_level(irq_level_q), .iack_strobe,
        .iack_level);
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("CHECK FAILED at %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic end_sim;
        $display("Comparisons %0d, mismatches %0d", n_checks, n_fail);
        if (n_fail == 0 && n_checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] x);
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= x;
        s_axi_awvalid <= 1;
        s_axi_wvalid <= 1;
        forever begin
            @(posedge aclk);
            if (s_axi_awready) s_axi_awvalid <= 0;
            if (s_axi_wready) s_axi_wvalid <= 0;
            if (s_axi_bvalid && s_axi_bready) break;
            s_axi_bready <= s_axi_bvalid;
        end
        r = s_axi_bresp;
        s_axi_bready <= 0;
    endtask
    task automatic rd(input logic [7:0] a);
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1;
        forever begin
            @(posedge aclk);
            if (s_axi_arready) s_axi_arvalid <= 0;
            if (s_axi_rvalid && s_axi_rready) break;
            s_axi_rready <= s_axi_rvalid;
        end
        d = s_axi_rdata;
        r = s_axi_rresp;
        s_axi_rready <= 0;
    endtask
    task automatic wait_own;
        int c;
        c = own_cnt;
        repeat (20000) begin
            @(posedge aclk);
            if (own_cnt != c) break;
        end
        chk(32'(own_cnt - c), 32'h1);
    endtask
    initial begin
        v = $urandom(6);
        for (m = 0; m < 2; m++) begin
            aresetn <= 0;
            clock_mode_input <= m[0];
            repeat (16) @(posedge aclk);
            aresetn <= 1;
            @(posedge aclk);
            rd(`PTT_OFS_TIMER);
            chk(d, m ? 32'h0 : 32'h100);
        end
        rd(`PTT_OFS_CONTROL);
        chk(d, 32'h0F);
        repeat (4) begin
            v = $urandom;
            wr(`PTT_OFS_CONTROL, v);
            rd(`PTT_OFS_CONTROL);
            chk(d, v & 32'h7FF);
            wr(`PTT_OFS_TIMER, v);
            rd(`PTT_OFS_TIMER);
            chk(d, v & 32'h1FF);
        end
        wr(8'h14, v);
        chk(32'(r), 32'h2);
        rd(8'h14);
        chk(32'(r), 32'h2);
        wr(`PTT_OFS_TIMER, 32'h0);
        $display("Test registers ended");
        m = $urandom_range(9, 2);
        wr(`PTT_OFS_CONTROL, 32'h5A7);
        for (int p = 0; p < 2; p++) begin
            wr(`PTT_OFS_TIMER, 32'h0);
            wr(`PTT_OFS_TIMER, p ? 32'h102 : 32'(m));
            wait_own;
            wait_own;
            t1 = own_t;
            wait_own;
            chk(32'((own_t - t1) / 5), p ? 32'h2000 : 32'(8 * m));
            chk(32'(own_vec), 32'hA7);
        end
        $display("Test period ended");
        wr(`PTT_OFS_TIMER, 32'h9);
        slow <= 1;
        for (int l = 1; l < 8; l++) begin
            wait_own;
            wr(`PTT_OFS_CONTROL, 32'(l * 257));
            repeat (200) begin
                @(posedge aclk);
                if (irq_level_q != 0) break;
            end
            chk(32'(irq_level_q), 32'(l));
            wait_own;
            chk(32'(own_vec), 32'(l));
        end
        slow <= 0;
        $display("Test levels ended");
        wr(`PTT_OFS_CONTROL, 32'h0AA);
        rd(`PTT_OFS_STATUS);
        m = 0;
        repeat (100) begin
            @(posedge aclk);
            m += (irq_level_q != 0);
        end
        chk(32'(m), 32'h0);
        rd(`PTT_OFS_STATUS);
        chk(d & 32'h1, 32'h1);
        wr(`PTT_OFS_MASK, 32'h1);
        rd(`PTT_OFS_STATUS);
        repeat (100) begin
            @(posedge aclk);
            if (irq_q) break;
        end
        chk(32'(irq_q), 32'h1);
        wr(`PTT_OFS_TIMER, 32'h0);
        rd(`PTT_OFS_STATUS);
        @(posedge aclk);
        chk(32'(irq_q), 32'h0);
        repeat (200) @(posedge aclk);
        rd(`PTT_OFS_STATUS);
        chk(d & 32'h1, 32'h0);
        wr(`PTT_OFS_MASK, 32'h0);
        wr(`PTT_OFS_TIMER, 32'hFF);
        repeat (20) @(posedge aclk);
        rd(`PTT_OFS_COUNT);
        v = d;
        clk_en <= 0;
        repeat (400) @(posedge aclk);
        clk_en <= 1;
        rd(`PTT_OFS_COUNT);
        chk(32'((v - d) < 32'h4), 32'h1);
        wr(`PTT_OFS_TIMER, 32'h0);
        $display("Test disable ended");
        wr(`PTT_OFS_CONTROL, 32'h4C3);
        wr(`PTT_OFS_TIMER, 32'h9);
        ext_irq_level <= 4;
        wait_own;
        chk(32'(own_vec), 32'hC3);
        ext_irq_level <= 0;
        $display("Test priority ended");
        end_sim;
    end
    initial begin
        #400000;
        n_fail++;
        end_sim;
    end
endmodule // ptt_timer_tb_top
